// [src/ebus_defs.svh]
// Constants of the external memory bus controller: offsets, fields, timing.
// Assumes a single 100 MHz clock and inclusion by every design file.
`ifndef EBUS_DEFS_SVH
`define EBUS_DEFS_SVH

// ==========================================================
// Register offsets
`define EBUS_OFS_CTRL    6'h00
`define EBUS_OFS_ADDR    6'h01
`define EBUS_OFS_WDATA   6'h02
`define EBUS_OFS_CMD     6'h03
`define EBUS_OFS_STATUS  6'h04
`define EBUS_OFS_RDATA   6'h05

// ==========================================================
// Fields
`define EBUS_CTRL_SINGLE 0
`define EBUS_CTRL_MUX    1
`define EBUS_CMD_GO      0
`define EBUS_CMD_WRITE   1
`define EBUS_CMD_WORD    2
`define EBUS_SPACE_HI    23
`define EBUS_SPACE_LO    22
`define EBUS_NARROW_SPACE 2'h3

// ==========================================================
// Timing
`define EBUS_CLK_NS      10
`define EBUS_STROBE_NS   30
`define EBUS_STROBE_CYC  (`EBUS_STROBE_NS / `EBUS_CLK_NS)
`define EBUS_STROBE_LAST 2'(`EBUS_STROBE_CYC - 1)
// The strap only reaches the second flop after two edges out of reset
`define EBUS_BOOT_LATCH  2'h2
`define EBUS_BOOT_SETTLE 2'h3
`define EBUS_SYNC_RESET  20'hfffff

`endif

// [src/ebus_pkg.sv]
// Types of the external memory bus controller.
// Assumes nothing beyond the constants header.
`include "ebus_defs.svh"

package ebus_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_STROBE,
        ST_RECOVER,
        ST_HOLD
    } bus_state_t;

    typedef struct packed {
        bus_state_t  st;
        logic        single_strobe;
        logic        mux_mode;
        logic [23:0] ext_addr;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic        is_write;
        logic        is_word;
        logic        boot_micro;
        logic [1:0]  boot_cnt;
        logic [1:0]  cnt;
        logic        wr_pend;
        logic [5:0]  wr_word;
        logic [31:0] hrdata;
    } ebus_state_t;

endpackage

// [src/ebus_sync.sv]
// Two-flop synchroniser for pins entering the bus clock domain.
// Assumes the inputs are asynchronous levels.
`timescale 1ns/10ps
`default_nettype none
`include "ebus_defs.svh"

module ebus_sync #(
    parameter int          WIDTH     = 20,
    parameter logic [19:0] RESET_VAL = `EBUS_SYNC_RESET
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // First stage feeds the second stage only
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            meta_reg <= RESET_VAL[WIDTH-1:0];
            sync_out <= RESET_VAL[WIDTH-1:0];
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule

`default_nettype wire

// [src/ebus_ctrl.sv]
// External memory bus controller with an AHB-Lite register slave.
// Assumes one 100 MHz clock; pins are outside its domain and synchronised.
//
// Local design decisions: register access over AHB-Lite and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "ebus_defs.svh"

module ebus_ctrl (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        boot_mode_select,
    input  wire logic        narrow_bus_select,
    input  wire logic        hold_req_n,
    input  wire logic        wait_insert_n,
    output logic             bus_grant_ack_n,
    output logic [22:0]      addr_out,
    output logic             top_address_bit_inverted,
    output logic             addr_oe_n,
    input  wire logic [15:0] dq_in,
    output logic [15:0]      dq_out,
    output logic [15:0]      dq_oe_n,
    output logic [3:0]       space_selects_n,
    output logic             store_strobe_even_n,
    output logic             store_strobe_odd_n,
    output logic             store_strobe_n,
    output logic             upper_lane_enable_n,
    output logic             read_strobe_n,
    output logic             ale,
    output logic             ctl_oe_n
);

    // ==========================================================
    // Pin synchronisers
    logic [19:0] sync_w;
    logic        hold_s;
    logic        wait_s;
    logic        boot_s;
    logic        narrow_s;
    logic [15:0] dq_s;

    ebus_sync #(
        .WIDTH     (20),
        .RESET_VAL (`EBUS_SYNC_RESET)
    ) u_sync (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .async_in ({hold_req_n, wait_insert_n, boot_mode_select,
                    narrow_bus_select, dq_in}),
        .sync_out (sync_w)
    );

    assign hold_s   = sync_w[19];
    assign wait_s   = sync_w[18];
    assign boot_s   = sync_w[17];
    assign narrow_s = sync_w[16];
    assign dq_s     = sync_w[15:0];

    // ==========================================================
    // State
    ebus_pkg::ebus_state_t s_reg;
    ebus_pkg::ebus_state_t s_next;

    function automatic logic [1:0] space_of(input logic [23:0] a);
        space_of = a[`EBUS_SPACE_HI:`EBUS_SPACE_LO];
    endfunction

    logic bus16;
    logic eff_word;
    logic lo_lane;
    logic hi_lane;
    logic busy;
    logic in_cycle;
    logic ap_valid;

    // Narrow select is read live; it must stay fixed by the board
    assign bus16 = !(space_of(s_reg.ext_addr) == `EBUS_NARROW_SPACE
                     && narrow_s);
    // Odd word addresses fall back to a byte access
    assign eff_word = s_reg.is_word && bus16 && !s_reg.ext_addr[0];
    assign lo_lane  = eff_word || !s_reg.ext_addr[0] || !bus16;
    assign hi_lane  = bus16 && (eff_word || s_reg.ext_addr[0]);
    assign busy     = s_reg.st != ebus_pkg::ST_IDLE
                      && s_reg.st != ebus_pkg::ST_HOLD;
    assign in_cycle = s_reg.st == ebus_pkg::ST_STROBE
                      || s_reg.st == ebus_pkg::ST_RECOVER;
    assign ap_valid = hsel && htrans[1] && hready;

    // ==========================================================
    // Next state
    always_comb
    begin
        s_next = s_reg;
        s_next.wr_pend = 1'b0;
        s_next.hrdata = 32'h0000_0000;

        // Boot level caught once the synchroniser has filled
        if (s_reg.boot_cnt != `EBUS_BOOT_SETTLE)
        begin
            s_next.boot_cnt = s_reg.boot_cnt + 2'h1;
            if (s_reg.boot_cnt == `EBUS_BOOT_LATCH)
                s_next.boot_micro = boot_s;
        end

        unique case (s_reg.st)
            ebus_pkg::ST_IDLE:
            begin
                if (!hold_s)
                    s_next.st = ebus_pkg::ST_HOLD;
            end
            ebus_pkg::ST_ADDR:
            begin
                s_next.st = ebus_pkg::ST_STROBE;
                s_next.cnt = 2'h0;
            end
            ebus_pkg::ST_STROBE:
            begin
                if (s_reg.cnt != `EBUS_STROBE_LAST)
                    s_next.cnt = s_reg.cnt + 2'h1;
                else if (wait_s)
                begin
                    s_next.st = ebus_pkg::ST_RECOVER;
                    if (!s_reg.is_write)
                    begin
                        if (eff_word)
                            s_next.rdata = dq_s;
                        else if (hi_lane)
                            s_next.rdata = {8'h00, dq_s[15:8]};
                        else
                            s_next.rdata = {8'h00, dq_s[7:0]};
                    end
                end
            end
            ebus_pkg::ST_RECOVER:
                s_next.st = ebus_pkg::ST_IDLE;
            ebus_pkg::ST_HOLD:
            begin
                if (hold_s)
                    s_next.st = ebus_pkg::ST_IDLE;
            end
            default:
                s_next.st = ebus_pkg::ST_IDLE;
        endcase

        // Register reads answer in the data phase
        if (ap_valid && !hwrite)
        begin
            unique case (haddr[7:2])
                `EBUS_OFS_CTRL:
                    s_next.hrdata = {30'h0, s_reg.mux_mode,
                                     s_reg.single_strobe};
                `EBUS_OFS_ADDR:
                    s_next.hrdata = {8'h00, s_reg.ext_addr};
                `EBUS_OFS_WDATA:
                    s_next.hrdata = {16'h0000, s_reg.wdata};
                `EBUS_OFS_STATUS:
                    s_next.hrdata = {28'h0, narrow_s, s_reg.boot_micro,
                                     s_reg.st == ebus_pkg::ST_HOLD, busy};
                `EBUS_OFS_RDATA:
                    s_next.hrdata = {16'h0000, s_reg.rdata};
                default:
                    s_next.hrdata = 32'h0000_0000;
            endcase
        end
        if (ap_valid && hwrite)
        begin
            s_next.wr_pend = 1'b1;
            s_next.wr_word = haddr[7:2];
        end

        // Register writes land with hwdata
        if (s_reg.wr_pend)
        begin
            unique case (s_reg.wr_word)
                `EBUS_OFS_CTRL:
                begin
                    s_next.single_strobe = hwdata[`EBUS_CTRL_SINGLE];
                    s_next.mux_mode = hwdata[`EBUS_CTRL_MUX];
                end
                `EBUS_OFS_ADDR:
                    s_next.ext_addr = hwdata[23:0];
                `EBUS_OFS_WDATA:
                    s_next.wdata = hwdata[15:0];
                `EBUS_OFS_CMD:
                begin
                    // Refused while busy, in hold or in single-chip mode
                    if (hwdata[`EBUS_CMD_GO] && s_reg.boot_micro
                        && s_reg.st == ebus_pkg::ST_IDLE && hold_s)
                    begin
                        s_next.st = ebus_pkg::ST_ADDR;
                        s_next.is_write = hwdata[`EBUS_CMD_WRITE];
                        s_next.is_word = hwdata[`EBUS_CMD_WORD];
                    end
                end
                default:
                    s_next.st = s_next.st;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s_reg <= '0;
            s_reg.st <= ebus_pkg::ST_IDLE;
        end
        else
            s_reg <= s_next;
    end

    // ==========================================================
    // AHB answer
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = s_reg.hrdata;

    // ==========================================================
    // Pins
    logic released;
    logic wr_on;

    assign released = s_reg.st == ebus_pkg::ST_HOLD;
    assign wr_on    = s_reg.is_write && s_reg.st == ebus_pkg::ST_STROBE;

    assign bus_grant_ack_n          = !released;
    assign addr_oe_n                = released;
    assign ctl_oe_n                 = released;
    assign addr_out                 = s_reg.ext_addr[22:0];
    assign top_address_bit_inverted = !s_reg.ext_addr[23];
    assign ale                      = s_reg.st == ebus_pkg::ST_ADDR;
    assign read_strobe_n = !(s_reg.st == ebus_pkg::ST_STROBE
                             && !s_reg.is_write);

    // Inactive scheme outputs idle high so the pin pairs can be merged
    assign store_strobe_even_n = !(wr_on && !s_reg.single_strobe
                                   && lo_lane);
    assign store_strobe_odd_n  = !(wr_on && !s_reg.single_strobe
                                   && hi_lane);
    assign store_strobe_n      = !(wr_on && s_reg.single_strobe);
    assign upper_lane_enable_n = !(busy && s_reg.single_strobe
                                   && (s_reg.ext_addr[0] || eff_word));

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_cs
            assign space_selects_n[g] = !(busy
                && space_of(s_reg.ext_addr) == 2'(g));
        end
    endgenerate

    always_comb
    begin
        dq_out  = 16'h0000;
        dq_oe_n = 16'hffff;
        if (s_reg.st == ebus_pkg::ST_ADDR && s_reg.mux_mode)
        begin
            dq_out[7:0] = s_reg.ext_addr[7:0];
            dq_oe_n[7:0] = 8'h00;
            if (bus16)
            begin
                dq_out[15:8] = s_reg.ext_addr[15:8];
                dq_oe_n[15:8] = 8'h00;
            end
        end
        else if (in_cycle && s_reg.is_write)
        begin
            if (eff_word)
                dq_out = s_reg.wdata;
            else if (hi_lane)
                dq_out[15:8] = s_reg.wdata[7:0];
            else
                dq_out[7:0] = s_reg.wdata[7:0];
            if (lo_lane)
                dq_oe_n[7:0] = 8'h00;
            if (hi_lane)
                dq_oe_n[15:8] = 8'h00;
        end
    end

    // ==========================================================
    // Checks
    sequence seq_addr;
        s_reg.st == ebus_pkg::ST_ADDR && ale;
    endsequence

    sequence seq_strobe;
        s_reg.st == ebus_pkg::ST_STROBE ##1 s_reg.st == ebus_pkg::ST_STROBE;
    endsequence

    AST_ALE_THEN_STROBE: assert property (@(posedge hclk) disable iff (!hresetn)
        seq_addr |=> seq_strobe ##1 s_reg.st == ebus_pkg::ST_STROBE)
        else $error("strobe did not follow latch");

    AST_HOLD_ENTER: assert property (@(posedge hclk) disable iff (!hresetn)
        s_reg.st == ebus_pkg::ST_IDLE && !hold_s && !s_reg.wr_pend
        |=> released && !bus_grant_ack_n)
        else $error("hold not entered");

    AST_HOLD_RELEASE: assert property (@(posedge hclk) disable iff (!hresetn)
        !bus_grant_ack_n |-> addr_oe_n && ctl_oe_n && dq_oe_n == 16'hffff)
        else $error("bus driven during hold");

    AST_HOLD_STAY: assert property (@(posedge hclk) disable iff (!hresetn)
        released && !hold_s |=> !bus_grant_ack_n)
        else $error("hold left early");

    AST_WAIT_EXTEND: assert property (@(posedge hclk) disable iff (!hresetn)
        s_reg.st == ebus_pkg::ST_STROBE && s_reg.cnt == `EBUS_STROBE_LAST
        && !wait_s |=> s_reg.st == ebus_pkg::ST_STROBE)
        else $error("wait ignored");

    AST_TOP_INVERT: assert property (@(posedge hclk) disable iff (!hresetn)
        top_address_bit_inverted != s_reg.ext_addr[23])
        else $error("top address bit not inverted");

    AST_MUX_ADDR: assert property (@(posedge hclk) disable iff (!hresetn)
        ale && s_reg.mux_mode |-> dq_out[7:0] == s_reg.ext_addr[7:0]
        && dq_oe_n[7:0] == 8'h00)
        else $error("mux address missing");

    AST_NARROW: assert property (@(posedge hclk) disable iff (!hresetn)
        in_cycle && !bus16 |-> dq_oe_n[15:8] == 8'hff)
        else $error("upper lane used on narrow bus");

    AST_EVEN_ODD: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_on && !s_reg.single_strobe && bus16 && !eff_word
        |-> store_strobe_even_n == s_reg.ext_addr[0]
        && store_strobe_odd_n == !s_reg.ext_addr[0])
        else $error("byte strobe wrong");

    AST_CS_ONEHOT: assert property (@(posedge hclk) disable iff (!hresetn)
        busy |-> $onehot(~space_selects_n)
        && !space_selects_n[space_of(s_reg.ext_addr)])
        else $error("chip select wrong");

    AST_SINGLE_CHIP: assert property (@(posedge hclk) disable iff (!hresetn)
        !s_reg.boot_micro |-> !busy)
        else $error("bus cycle in single-chip mode");

endmodule

`default_nettype wire

// [dv/ext_mem_model.sv]
// Behavioural external memory on the far side of the bus controller.
// Assumes the controller's pin outputs and its bus clock.
`timescale 1ns/10ps
`default_nettype none

module ext_mem_model (
    input  wire logic        hclk,
    input  wire logic [22:0] addr_out,
    input  wire logic [15:0] dq_out,
    input  wire logic [15:0] dq_oe_n,
    input  wire logic [3:0]  space_selects_n,
    input  wire logic        store_strobe_even_n,
    input  wire logic        store_strobe_odd_n,
    input  wire logic        store_strobe_n,
    input  wire logic        upper_lane_enable_n,
    input  wire logic        read_strobe_n,
    input  wire logic        ale,
    input  wire logic        narrow,
    input  wire logic [3:0]  wait_len,
    output logic [15:0]      dq_in,
    output logic             wait_insert_n
);
    logic [7:0]  mem [256];
    logic [7:0]  a = 8'h0;
    logic [15:0] last = 16'h0;
    logic [3:0]  cnt = 4'h0;
    logic        strb;
    logic        nar;

    // ==========================================================
    // Pins
    assign strb = !read_strobe_n || !store_strobe_n
        || !store_strobe_even_n || !store_strobe_odd_n;
    assign nar = narrow && !space_selects_n[3];
    // Released lines show the inverse of the last value, never a stale copy
    assign dq_in = !read_strobe_n
        ? {mem[a | 8'h1], nar ? mem[a] : mem[a & 8'hfe]} : ~last;
    // Slow device: holds the cycle off for wait_len strobe cycles
    assign wait_insert_n = !(strb && cnt < wait_len);

    // ==========================================================
    // Storage
    always @(posedge hclk)
    begin
        if (ale)
            a <= dq_oe_n[0] ? addr_out[7:0] : dq_out[7:0];
        cnt <= strb ? cnt + 4'h1 : 4'h0;
        if (!read_strobe_n)
            last <= dq_in;
        if (!store_strobe_even_n)
            mem[a & 8'hfe] <= dq_out[7:0];
        if (!store_strobe_odd_n)
            mem[a | 8'h1] <= dq_out[15:8];
        if (!store_strobe_n && (nar || !a[0]))
            mem[a] <= dq_out[7:0];
        if (!store_strobe_n && !nar && (a[0] || !upper_lane_enable_n))
            mem[a | 8'h1] <= dq_out[15:8];
    end
endmodule

`default_nettype wire

// [dv/tb_top.sv]
// Self-checking bench: register traffic, external cycles, hold, reset.
// Assumes the memory model file and a 100 MHz clock.
`timescale 1ns/10ps
`default_nettype none
`define CHK(act, exp, msg) begin comparisons++; if ((act) !== (exp)) \
    begin fails++; $display("wrong value %0t %s", $time, msg); end end

module tb_top;
    localparam logic [31:0] a_ctrl = 32'h00, a_addr = 32'h04;
    localparam logic [31:0] a_wdata = 32'h08, a_cmd = 32'h0c;
    localparam logic [31:0] a_stat = 32'h10, a_rdata = 32'h14;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, hr_q;
    logic [1:0] htrans = '0, ctrl_q = '0;
    logic hreadyout, hresp, boot_mode_select = 1'b0, ale, ctl_oe_n;
    logic narrow_bus_select = 1'b0, hold_req_n = 1'b1, wait_insert_n;
    logic bus_grant_ack_n, top_address_bit_inverted, addr_oe_n;
    logic [22:0] addr_out;
    logic [15:0] dq_in, dq_out, dq_oe_n;
    logic [3:0] space_selects_n, wait_len = 4'h0;
    logic store_strobe_even_n, store_strobe_odd_n, store_strobe_n;
    logic upper_lane_enable_n, read_strobe_n, nar_cyc = 1'b0, mux_on = 1'b0;
    logic [9:0] seen = '0;
    logic [23:0] exp_a = '0;
    logic [7:0] ref_mem [256];
    int fails = 0, comparisons = 0, cyc = 0, slen = 0;

    always #5 hclk = ~hclk;

    ebus_ctrl dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
        .hrdata, .boot_mode_select, .narrow_bus_select, .hold_req_n,
        .wait_insert_n, .bus_grant_ack_n, .addr_out,
        .top_address_bit_inverted, .addr_oe_n, .dq_in, .dq_out, .dq_oe_n,
        .space_selects_n, .store_strobe_even_n, .store_strobe_odd_n,
        .store_strobe_n, .upper_lane_enable_n, .read_strobe_n, .ale,
        .ctl_oe_n);

    ext_mem_model mem_u (.hclk, .addr_out, .dq_out, .dq_oe_n,
        .space_selects_n, .store_strobe_even_n, .store_strobe_odd_n,
        .store_strobe_n, .upper_lane_enable_n, .read_strobe_n, .ale,
        .narrow(narrow_bus_select), .wait_len, .dq_in, .wait_insert_n);

    // ==========================================================
    // Pin monitor
    always @(posedge hclk)
    begin
        hr_q <= hrdata;
        cyc <= cyc + 1;
        if (ale)
        begin
            `CHK(top_address_bit_inverted, ~exp_a[23], "top bit")
            `CHK(addr_out[22:16], exp_a[22:16], "high address")
            if (!mux_on)
                `CHK(addr_out[15:0], exp_a[15:0], "address")
            else
                `CHK(dq_out[7:0], exp_a[7:0], "shared low")
            if (mux_on && !nar_cyc)
                `CHK(dq_out[15:8], exp_a[15:8], "shared mid")
        end
        seen <= seen | {~space_selects_n, ~store_strobe_even_n,
            ~store_strobe_odd_n, ~store_strobe_n, ~upper_lane_enable_n,
            ~read_strobe_n, ~&dq_oe_n[15:8]};
        if (!read_strobe_n || !store_strobe_n || !store_strobe_even_n
            || !store_strobe_odd_n)
            slen <= slen + 1;
        if (cyc == 8000)
        begin
            fails++;
            $display("wrong value %0t timeout", $time);
            tally_and_finish;
        end
    end

    // ==========================================================
    // Tasks
    task automatic ahb(input logic w, input logic [31:0] a,
        input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        #1 r = hr_q;
    endtask

    task automatic op(input logic wr, input logic wd, input logic [23:0] a);
        logic [31:0] r;
        logic [15:0] d;
        logic [7:0] k;
        logic odd, nr, both, sgl;
        logic [1:0] pe;
        d = 16'($urandom);
        k = a[7:0];
        odd = a[0];
        nr = narrow_bus_select && a[23:22] == 2'h3;
        both = wd && !odd && !nr;
        sgl = ctrl_q[0];
        exp_a = a;
        nar_cyc = nr;
        ahb(1'b1, a_addr, {8'h0, a}, r);
        ahb(1'b1, a_wdata, {16'h0, d}, r);
        seen = '0;
        slen = 0;
        ahb(1'b1, a_cmd, {29'h0, wd, wr, 1'b1}, r);
        repeat (40)
        begin
            ahb(1'b0, a_stat, 32'h0, r);
            if (r[0] === 1'b0) break;
        end
        `CHK(seen[9:6], 4'(1 << a[23:22]), "select")
        pe = sgl ? 2'b00 : {wr && !odd, wr && (both || odd)};
        `CHK(seen[5:4], pe, "pair strobes")
        `CHK(seen[3], sgl && wr, "write strobe")
        if (!nr) `CHK(seen[2], sgl && (odd || both), "lane enable")
        `CHK(seen[1], !wr, "read strobe")
        if (nr) `CHK(seen[0], 1'b0, "upper lanes")
        if (wait_len == 0) `CHK(slen, 3, "strobe length")
        else `CHK(slen > wait_len, 1'b1, "wait extension")
        if (wr)
        begin
            ref_mem[k] = d[7:0];
            if (both) ref_mem[k | 8'h1] = d[15:8];
        end
        else
        begin
            ahb(1'b0, a_rdata, 32'h0, r);
            `CHK(r[7:0], ref_mem[k], "low byte")
            if (both) `CHK(r[15:8], ref_mem[k | 8'h1], "high byte")
        end
    endtask

    task automatic do_reset(input logic b, input logic n);
        @(posedge hclk);
        hresetn <= 1'b0;
        boot_mode_select <= b;
        narrow_bus_select <= n;
        repeat (3) @(posedge hclk);
        #1;
        `CHK({bus_grant_ack_n, read_strobe_n, store_strobe_n}, 3'h7, "rst")
        `CHK({space_selects_n, ale}, 5'h1e, "reset selects")
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (6) @(posedge hclk);
    endtask

    task tally_and_finish;
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ==========================================================
    // Sequence
    initial
    begin
        logic [31:0] r;
        logic [23:0] a;
        logic wd;
        void'($urandom(7));
        for (int ph = 0; ph < 3; ph++)
        begin
            do_reset(ph > 0, ph == 2);
            ahb(1'b0, a_stat, 32'h0, r);
            `CHK(r[2], ph > 0, "boot mode")
            `CHK(r[3], ph == 2, "narrow status")
            if (ph == 0)
            begin
                seen = '0;
                ahb(1'b1, a_cmd, 32'h7, r);
                repeat (8) @(posedge hclk);
                `CHK(seen[9:6], 4'h0, "access in single-chip")
            end
            for (int i = 0; i < 16 && ph > 0; i++)
            begin
                ctrl_q = {i[1], ph == 2 || i[0]};
                mux_on = ctrl_q[1];
                ahb(1'b1, a_ctrl, {30'h0, ctrl_q}, r);
                a = 24'($urandom);
                a[23:22] = ph == 2 ? 2'h3 : i[3:2];
                wd = 1'($urandom);
                op(1'b1, wd, a);
                op(1'b0, wd, a);
            end
        end
        // Slow partner: both directions stretched by wait states
        wait_len = 4'h4;
        op(1'b1, 1'b1, a);
        op(1'b0, 1'b1, a);
        wait_len = 4'h0;
        @(posedge hclk);
        hold_req_n <= 1'b0;
        repeat (6) @(posedge hclk);
        #1;
        `CHK({bus_grant_ack_n, addr_oe_n, ctl_oe_n}, 3'h3, "hold pins")
        `CHK(dq_oe_n, 16'hffff, "hold data")
        seen = '0;
        ahb(1'b1, a_cmd, 32'h1, r);
        ahb(1'b0, a_stat, 32'h0, r);
        `CHK(r[1:0], 2'b10, "hold status")
        `CHK(seen[9:6], 4'h0, "access in hold")
        @(posedge hclk);
        hold_req_n <= 1'b1;
        repeat (6) @(posedge hclk);
        `CHK(bus_grant_ack_n, 1'b1, "hold release")
        ahb(1'b0, 32'h3c, 32'h0, r);
        `CHK(r, 32'h0, "unmapped read")
        tally_and_finish;
    end
endmodule

`default_nettype wire
